// [rtl/rt_sup_params.svh]
`ifndef RT_SUP_PARAMS_SVH
`define RT_SUP_PARAMS_SVH

// System clock rate and timing figures
`define CLK_FREQ_MHZ        125
`define NORESP_LONG_US      31
`define NORESP_SHORT_US     14
`define LOOP_STOP_US        3
`define TX_LIMIT_US         800
`define NORESP_LONG_CYC     (`NORESP_LONG_US * `CLK_FREQ_MHZ)
`define NORESP_SHORT_CYC    (`NORESP_SHORT_US * `CLK_FREQ_MHZ)
`define LOOP_STOP_CYC       (`LOOP_STOP_US * `CLK_FREQ_MHZ)
`define TX_LIMIT_CYC        (`TX_LIMIT_US * `CLK_FREQ_MHZ)
`define RX_END_CYCLES       8

// Register offsets (byte addresses)
`define REG_CONFIG          8'h00
`define REG_STATUS          8'h04
`define REG_LAST_CMD        8'h08
`define REG_BIT             8'h0c
`define REG_CHAR            8'h10
`define REG_STATE           8'h14
`define CFG_LEGAL_BIT       0
`define CFG_WRAP_BIT        1
`define CFG_RESET           2'h0

// Characterization table bases
`define CHAR_RX_MC          16'h0200
`define CHAR_RX_BC_MC       16'h0220
`define CHAR_RX_SA          16'h0240
`define CHAR_RX_BC_SA       16'h0260
`define CHAR_TX_MC          16'h0280
`define CHAR_TX_BC_MC       16'h02a0
`define CHAR_TX_SA          16'h02c0

// Characterization word fields
`define CW_ILLEGAL          0
`define CW_DWC_HI           5
`define CW_DWC_LO           1
`define CW_MODE_HI          7
`define CW_MODE_LO          6
`define CW_CHECK            8
`define CW_NOT_READY        9
`define CW_BUF_HI           12
`define CW_BUF_LO           10

// BIT word fields
`define BIT_TIMEOUT_RED     13
`define BIT_TIMEOUT_NOM     12
`define BIT_HIGH_COUNT      6
`define BIT_LOW_COUNT       5
`define BIT_LOOP            2
`define BIT_BUSY            1
`define BIT_TIMEOUT         0

// Command word details
`define BCAST_ADDR          5'h1f
`define WRAP_SA             5'h1e
`define WRAP_DEPTH          32
`define MC_TX_STATUS        5'h02
`define MC_TX_LAST_CMD      5'h12
`define MC_TX_BIT           5'h13

`endif

// [rtl/rt_sup_pkg.sv]
package rt_sup_pkg;

	typedef enum logic [4:0]
	{
		ST_IDLE   = 5'h01,
		ST_FETCH  = 5'h02,
		ST_RX     = 5'h04,
		ST_RX_END = 5'h08,
		ST_TX     = 5'h10
	} sup_state_e;

	typedef logic [15:0] word_t;

endpackage

// [rtl/wrap_buffer.sv]
`timescale 1ns/1ps
`include "rt_sup_params.svh"

module wrap_buffer
	import rt_sup_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       wr_en,
	input  wire word_t      wr_data,
	input  wire logic       rd_rewind,
	input  wire logic       rd_en,
	output word_t           rd_data,
	output logic            rd_valid,
	output logic [5:0]      count
);

	word_t      mem [0:`WRAP_DEPTH-1];
	logic [5:0] rd_ptr;

	// Write side; words past the depth are dropped
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			count <= 6'h00;
		else if (clear)
			count <= 6'h00;
		else if (wr_en && count < 6'(`WRAP_DEPTH))
			count <= count + 6'h01;
	end

	// Storage has no reset, contents only valid below count
	always_ff @(posedge clk)
	begin
		if (wr_en && !clear && count < 6'(`WRAP_DEPTH))
			mem[count[4:0]] <= wr_data;
	end

	// Read side, one word per request
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_ptr   <= 6'h00;
			rd_data  <= 16'h0000;
			rd_valid <= 1'b0;
		end
		else
		begin
			rd_valid <= 1'b0;
			if (rd_rewind || clear)
				rd_ptr <= 6'h00;
			else if (rd_en && rd_ptr < count)
			begin
				rd_data  <= mem[rd_ptr[4:0]];
				rd_valid <= 1'b1;
				rd_ptr   <= rd_ptr + 6'h01;
			end
		end
	end

endmodule

// [rtl/rt_bus_supervision_legality.sv]
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rt_sup_params.svh"

// Contract
// - RT-to-RT no-response timeout is 31 us with select low, 14 us high.
// - Commands taken on either bus; the reply goes out on the same bus.
// - Status, last command and BIT track the latest transfer on any bus.
// - Valid command on the other bus mid-transfer abandons the current one.
// - Command on alternate bus during receive wrap-up answers with busy set.
// - Loop test mismatch stops emission within 3 us, sets TF and BIT.
// - Emission over 800 us is cut, BIT and TF set, until next valid command.
// - Subaddress 30 receive data is returned by a later transmit to it.
// - Config field picks internal wrap buffer or application-stored wrap.
// - Wrap test accepts 1 to 32 data words.
// - Config field enables legality; when off every message is legal.
// - Characterization word is read every transfer but transmit status and last command, legality on or off; code skips it for deferred commands.
// - Receive mode codes from 0x0200, broadcast 0x0220, subaddresses 0x0241.
// - Transmit mode codes from 0x0280, broadcast transmit from 0x02A0.
// - Broadcast receive subaddresses 0x0261 up, transmit 0x02C1 to 0x02DE.
// - Transmit status and last command need no word, always legal.
// - Bit 0 set marks illegal and sets message error in status.
// - Bits 12 to 10 give circular buffer size, 64 doubling to 8192.
// - Bit 9 set means data block not ready: no data read or write.
// - Bit 8 enables word count check against bits 5 to 1, 0 is 32.
// - Bits 7 to 6 select direct, indirect or indirect stacked memory.
module rt_bus_supervision_legality
	import rt_sup_pkg::*;
#(
	parameter int TX_LIMIT_CYCLES = `TX_LIMIT_CYC
)
(
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        wb_cyc,
	input  wire logic        wb_stb,
	input  wire logic        wb_we,
	input  wire logic [7:0]  wb_adr,
	input  wire logic [3:0]  wb_sel,
	input  wire logic [31:0] wb_dat_wr,
	output logic [31:0]      wb_dat_rd,
	output logic             wb_ack,
	input  wire logic [4:0]  rt_address,
	input  wire logic        timeout_select,
	input  wire logic        loop_test_enable_n,
	input  wire logic [1:0]  cmd_valid,
	input  wire word_t       cmd_word_nom,
	input  wire word_t       cmd_word_red,
	input  wire logic        rx_word_valid,
	input  wire word_t       rx_word,
	input  wire logic        rx_msg_done,
	input  wire logic        tx_word_valid,
	input  wire word_t       tx_word,
	input  wire logic        echo_valid,
	input  wire word_t       echo_word,
	input  wire logic        tx_msg_done,
	input  wire logic        tx_wrap_req,
	input  wire logic        rtrt_wait_start,
	input  wire logic        rtrt_status_seen,
	output logic             app_req,
	output word_t            app_addr,
	input  wire logic        app_ack,
	input  wire word_t       app_rdata,
	output logic             reply_start,
	output logic             reply_bus,
	output word_t            status_word,
	output logic [1:0]       tx_enable,
	output logic             abort_pulse,
	output logic             data_access_enable,
	output logic [1:0]       memory_mode,
	output logic [2:0]       circular_buffer_size,
	output logic [5:0]       expected_word_count,
	output logic             wrap_internal_active,
	output word_t            wrap_word,
	output logic             wrap_word_valid,
	output logic             noresp_timeout
);

	// Command word helpers
	function automatic logic is_mode(input word_t w);
		is_mode = (w[9:5] == 5'h00) || (w[9:5] == 5'h1f);
	endfunction

	function automatic logic is_bcst(input word_t w);
		is_bcst = (w[15:11] == `BCAST_ADDR);
	endfunction

	function automatic logic is_mc(input word_t w, input logic [4:0] code);
		is_mc = is_mode(w) && w[10] && (w[4:0] == code);
	endfunction

	// Table address taken from the command word alone
	function automatic word_t char_addr(input word_t w);
		word_t base;
		logic  [4:0] idx;
		idx = is_mode(w) ? w[4:0] : w[9:5];
		if (w[10])
			base = is_mode(w) ? (is_bcst(w) ? `CHAR_TX_BC_MC : `CHAR_TX_MC)
			                  : `CHAR_TX_SA;
		else if (is_mode(w))
			base = is_bcst(w) ? `CHAR_RX_BC_MC : `CHAR_RX_MC;
		else
			base = is_bcst(w) ? `CHAR_RX_BC_SA : `CHAR_RX_SA;
		char_addr = base | {11'h000, idx};
	endfunction

	logic        rst_meta_n;
	logic        rst_n;
	sup_state_e  state;
	sup_state_e  next_state;
	word_t       cur_cmd;
	logic        cur_bus;
	logic        pending;
	word_t       pend_cmd;
	logic        pend_bus;
	logic [3:0]  rx_end_cnt;
	logic [1:0]  cfg;
	word_t       last_cmd;
	word_t       bit_word;
	word_t       char_word;
	logic        illegal_msg;
	logic        blk_not_ready;
	logic        chk_en;
	logic        me_flag;
	logic        busy_flag;
	logic        tf_flag;
	logic        bcst_flag;
	logic [1:0]  inhibit;
	logic [5:0]  rx_cnt;
	word_t       exp_word;
	logic        echo_pending;
	logic [8:0]  loop_cnt;
	logic [16:0] tx_cnt;
	logic        noresp_run;
	logic [11:0] noresp_cnt;
	logic        hit_nom;
	logic        hit_red;
	logic        new_cmd;
	word_t       new_word;
	logic        new_bus;
	logic        defer;
	logic        accept;
	logic        launch_pend;
	logic        enter_tx;
	logic        loop_err;
	logic        fetch_illegal;
	logic        tx_limit_hit;
	logic        count_hi;
	logic        count_lo;
	logic        wrap_sa;
	logic [5:0]  wrap_count;

	// Reset release through two flops
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// Command pick; nominal wins a same-cycle tie
	assign hit_nom  = cmd_valid[0] && (cmd_word_nom[15:11] == rt_address || is_bcst(cmd_word_nom));
	assign hit_red  = cmd_valid[1] && (cmd_word_red[15:11] == rt_address || is_bcst(cmd_word_red));
	assign new_cmd  = hit_nom || hit_red;
	assign new_word = hit_nom ? cmd_word_nom : cmd_word_red;
	assign new_bus  = !hit_nom;
	// Other bus during receive wrap-up is held off to protect stored data
	assign defer    = new_cmd && state == ST_RX_END && new_bus != cur_bus;
	assign accept   = new_cmd && !defer;
	assign launch_pend = state == ST_RX_END && rx_end_cnt == 4'h0 && (pending || defer);
	assign enter_tx = next_state == ST_TX && (state != ST_TX || accept);

	// Next state
	always_comb
	begin
		next_state = state;
		if (accept)
		begin
			if (is_mc(new_word, `MC_TX_STATUS) || is_mc(new_word, `MC_TX_LAST_CMD))
				next_state = is_bcst(new_word) ? ST_IDLE : ST_TX;
			else
				next_state = ST_FETCH;
		end
		else
		begin
			case (state)
				ST_IDLE:
					next_state = ST_IDLE;
				ST_FETCH:
					if (app_ack)
						next_state = !cur_cmd[10] ? ST_RX : (is_bcst(cur_cmd) ? ST_IDLE : ST_TX);
				ST_RX:
					if (rx_msg_done)
						next_state = ST_RX_END;
				ST_RX_END:
					if (rx_end_cnt == 4'h0)
						next_state = (launch_pend || !is_bcst(cur_cmd)) ? ST_TX : ST_IDLE;
				ST_TX:
					if (tx_msg_done || loop_err || tx_limit_hit)
						next_state = ST_IDLE;
				default:
					next_state = ST_IDLE;
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state       <= ST_IDLE;
			cur_cmd     <= 16'h0000;
			cur_bus     <= 1'b0;
			pending     <= 1'b0;
			pend_cmd    <= 16'h0000;
			pend_bus    <= 1'b0;
			rx_end_cnt  <= 4'h0;
			app_addr    <= 16'h0000;
			abort_pulse <= 1'b0;
			reply_start <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			abort_pulse <= accept && state != ST_IDLE;
			reply_start <= enter_tx;
			if (accept)
			begin
				cur_cmd  <= new_word;
				cur_bus  <= new_bus;
				app_addr <= char_addr(new_word);
				pending  <= 1'b0;
			end
			else if (launch_pend)
			begin
				cur_cmd <= pending ? pend_cmd : new_word;
				cur_bus <= pending ? pend_bus : new_bus;
				pending <= 1'b0;
			end
			else if (defer)
			begin
				pending  <= 1'b1;
				pend_cmd <= new_word;
				pend_bus <= new_bus;
			end
			if (state == ST_RX && rx_msg_done)
				rx_end_cnt <= 4'(`RX_END_CYCLES - 1);
			else if (state == ST_RX_END && rx_end_cnt != 4'h0)
				rx_end_cnt <= rx_end_cnt - 4'h1;
		end
	end

	assign app_req   = state == ST_FETCH;
	assign reply_bus = cur_bus;

	// Characterization word capture
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			char_word            <= 16'h0000;
			illegal_msg          <= 1'b0;
			blk_not_ready        <= 1'b0;
			chk_en               <= 1'b0;
			memory_mode          <= 2'h0;
			circular_buffer_size <= 3'h0;
			expected_word_count  <= 6'h20;
		end
		else if (accept)
		begin
			illegal_msg   <= 1'b0;
			blk_not_ready <= 1'b0;
			chk_en        <= 1'b0;
		end
		else if (state == ST_FETCH && app_ack)
		begin
			char_word            <= app_rdata;
			illegal_msg          <= cfg[`CFG_LEGAL_BIT] && app_rdata[`CW_ILLEGAL];
			blk_not_ready        <= !is_mode(cur_cmd) && app_rdata[`CW_NOT_READY];
			chk_en               <= !is_mode(cur_cmd) && app_rdata[`CW_CHECK];
			memory_mode          <= app_rdata[`CW_MODE_HI:`CW_MODE_LO];
			circular_buffer_size <= app_rdata[`CW_BUF_HI:`CW_BUF_LO];
			expected_word_count  <= (app_rdata[`CW_DWC_HI:`CW_DWC_LO] == 5'h00) ? 6'h20
			                        : {1'b0, app_rdata[`CW_DWC_HI:`CW_DWC_LO]};
		end
	end

	// Illegal, not-ready or busy messages touch no data
	assign data_access_enable = (state == ST_RX || state == ST_TX) && !illegal_msg
	                            && !blk_not_ready && !busy_flag;

	// Received word count check
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rx_cnt <= 6'h00;
		else if (state != ST_RX)
			rx_cnt <= 6'h00;
		else if (rx_word_valid && rx_cnt != 6'h3f)
			rx_cnt <= rx_cnt + 6'h01;
	end

	assign count_hi = state == ST_RX && rx_msg_done && chk_en && rx_cnt > expected_word_count;
	assign count_lo = state == ST_RX && rx_msg_done && chk_en && rx_cnt < expected_word_count;

	// Status flags; a new transfer other than transmit status or last command clears them, events set them after
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			me_flag   <= 1'b0;
			busy_flag <= 1'b0;
			tf_flag   <= 1'b0;
			bcst_flag <= 1'b0;
		end
		else
		begin
			if (accept && !is_mc(new_word, `MC_TX_STATUS) && !is_mc(new_word, `MC_TX_LAST_CMD))
			begin
				me_flag   <= 1'b0;
				busy_flag <= 1'b0;
				tf_flag   <= 1'b0;
				bcst_flag <= is_bcst(new_word);
			end
			if (launch_pend)
			begin
				me_flag   <= 1'b0;
				busy_flag <= 1'b1;
				bcst_flag <= 1'b0;
			end
			if (state == ST_FETCH && app_ack && cfg[`CFG_LEGAL_BIT] && app_rdata[`CW_ILLEGAL])
				me_flag <= 1'b1;
			if (count_hi || count_lo)
				me_flag <= 1'b1;
			if (loop_err || tx_limit_hit)
				tf_flag <= 1'b1;
		end
	end

	// Table verdict of a transmit is needed in the very cycle its reply starts
	assign fetch_illegal = state == ST_FETCH && app_ack && cfg[`CFG_LEGAL_BIT]
	                       && app_rdata[`CW_ILLEGAL];

	// Reply status latched as the reply starts; a later fault still raises TF
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			status_word <= 16'h0000;
		else
		begin
			if (enter_tx && !(accept && is_mc(new_word, `MC_TX_STATUS))
			    && !(accept && is_mc(new_word, `MC_TX_LAST_CMD)))
				status_word <= {rt_address, me_flag || fetch_illegal, 5'h00,
				                bcst_flag, busy_flag || launch_pend, 2'h0, tf_flag};
			if (loop_err || tx_limit_hit)
				status_word[0] <= 1'b1;
		end
	end

	// Last command and BIT word follow the latest transfer on either bus
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_cmd <= 16'h0000;
			bit_word <= 16'h0000;
		end
		else
		begin
			if (accept && !is_mc(new_word, `MC_TX_LAST_CMD))
				last_cmd <= new_word;
			else if (launch_pend)
				last_cmd <= pending ? pend_cmd : new_word;
			if (accept && !is_mc(new_word, `MC_TX_LAST_CMD) && !is_mc(new_word, `MC_TX_STATUS)
			    && !is_mc(new_word, `MC_TX_BIT))
				bit_word <= 16'h0000;
			if (launch_pend)
				bit_word[`BIT_BUSY] <= 1'b1;
			if (count_hi)
				bit_word[`BIT_HIGH_COUNT] <= 1'b1;
			if (count_lo)
				bit_word[`BIT_LOW_COUNT] <= 1'b1;
			if (loop_err)
				bit_word[`BIT_LOOP] <= 1'b1;
			if (tx_limit_hit)
			begin
				bit_word[`BIT_TIMEOUT] <= 1'b1;
				if (cur_bus)
					bit_word[`BIT_TIMEOUT_RED] <= 1'b1;
				else
					bit_word[`BIT_TIMEOUT_NOM] <= 1'b1;
			end
		end
	end

	// Loop test: each emitted word must echo back unchanged in time
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			exp_word     <= 16'h0000;
			echo_pending <= 1'b0;
			loop_cnt     <= 9'h000;
		end
		else if (state != ST_TX || loop_test_enable_n)
		begin
			echo_pending <= 1'b0;
			loop_cnt     <= 9'h000;
		end
		else if (tx_word_valid)
		begin
			exp_word     <= tx_word;
			echo_pending <= 1'b1;
			loop_cnt     <= 9'(`LOOP_STOP_CYC - 1);
		end
		else if (echo_valid)
			echo_pending <= 1'b0;
		else if (echo_pending && loop_cnt != 9'h000)
			loop_cnt <= loop_cnt - 9'h001;
	end

	// A missing echo counts as a mismatch once the window runs out
	assign loop_err = state == ST_TX && !loop_test_enable_n && echo_pending && !tx_word_valid
	                  && ((echo_valid && echo_word != exp_word)
	                  || (!echo_valid && loop_cnt == 9'h000));

	// Emission length limit
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			tx_cnt <= 17'h00000;
		else if (state != ST_TX || accept)
			tx_cnt <= 17'h00000;
		else if (tx_cnt != 17'h1ffff)
			tx_cnt <= tx_cnt + 17'h00001;
	end

	assign tx_limit_hit = state == ST_TX && !inhibit[cur_bus]
	                      && tx_cnt == 17'(TX_LIMIT_CYCLES - 1);

	// Transmitter inhibit, lifted only by the next valid command
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			inhibit <= 2'h0;
		else
		begin
			if (accept)
				inhibit <= 2'h0;
			if (loop_err || tx_limit_hit)
				inhibit[cur_bus] <= 1'b1;
		end
	end

	assign tx_enable[0] = state == ST_TX && !cur_bus && !inhibit[0];
	assign tx_enable[1] = state == ST_TX && cur_bus && !inhibit[1];

	// RT-to-RT no-response watchdog
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			noresp_run     <= 1'b0;
			noresp_cnt     <= 12'h000;
			noresp_timeout <= 1'b0;
		end
		else
		begin
			noresp_timeout <= noresp_run && noresp_cnt == 12'h000 && !rtrt_status_seen;
			if (rtrt_wait_start)
			begin
				noresp_run <= 1'b1;
				noresp_cnt <= timeout_select ? 12'(`NORESP_SHORT_CYC - 1)
				                             : 12'(`NORESP_LONG_CYC - 1);
			end
			else if (rtrt_status_seen || abort_pulse || noresp_cnt == 12'h000)
				noresp_run <= 1'b0;
			else if (noresp_run)
				noresp_cnt <= noresp_cnt - 12'h001;
		end
	end

	// Wrap-around on subaddress 30
	assign wrap_sa = !is_mode(cur_cmd) && cur_cmd[9:5] == `WRAP_SA && !is_bcst(cur_cmd);
	assign wrap_internal_active = state == ST_TX && wrap_sa && cur_cmd[10]
	                              && cfg[`CFG_WRAP_BIT];

	wrap_buffer u_wrap
	(
		.clk       (sys_clk),
		.rst_n     (rst_n),
		.clear     (state == ST_FETCH && app_ack && wrap_sa && !cur_cmd[10]),
		.wr_en     (state == ST_RX && rx_word_valid && wrap_sa && !cur_cmd[10]
		            && cfg[`CFG_WRAP_BIT] && data_access_enable),
		.wr_data   (rx_word),
		.rd_rewind (state == ST_FETCH && app_ack && wrap_sa && cur_cmd[10]),
		.rd_en     (tx_wrap_req && wrap_internal_active && data_access_enable),
		.rd_data   (wrap_word),
		.rd_valid  (wrap_word_valid),
		.count     (wrap_count)
	);

	// Register bus: ack one cycle after request, write lands on ack edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wb_ack    <= 1'b0;
			wb_dat_rd <= 32'h00000000;
			cfg       <= `CFG_RESET;
		end
		else
		begin
			wb_ack <= wb_cyc && wb_stb && !wb_ack;
			if (wb_cyc && wb_stb && wb_we && wb_ack && wb_sel[0] && wb_adr == `REG_CONFIG)
				cfg <= wb_dat_wr[1:0];
			if (wb_cyc && wb_stb && !wb_ack)
			begin
				case (wb_adr)
					`REG_CONFIG:   wb_dat_rd <= {30'h00000000, cfg};
					`REG_STATUS:   wb_dat_rd <= {16'h0000, status_word};
					`REG_LAST_CMD: wb_dat_rd <= {16'h0000, last_cmd};
					`REG_BIT:      wb_dat_rd <= {16'h0000, bit_word};
					`REG_CHAR:     wb_dat_rd <= {16'h0000, char_word};
					`REG_STATE:    wb_dat_rd <= {18'h00000, wrap_count, pending, inhibit, state};
					default:       wb_dat_rd <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [test/rt_sup_assertions.sv]
`timescale 1ns/1ps
module rt_sup_checker
#(
	parameter int TX_LIMIT_CYCLES = 200
)
(
	input wire logic       sys_clk,
	input wire logic       nrst,
	input wire logic       wb_cyc,
	input wire logic       wb_stb,
	input wire logic       wb_ack,
	input wire logic       app_req,
	input wire logic       app_ack,
	input wire logic       reply_start,
	input wire logic       reply_bus,
	input wire logic [1:0] tx_enable
);
	int tx_run;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	// Emission length; slack of two for the cut-off registers
	always_ff @(posedge sys_clk or negedge nrst)
		if (!nrst)
			tx_run <= 0;
		else
			tx_run <= (tx_enable != 0) ? tx_run + 1 : 0;
	ack_next_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack |=> !wb_ack)
		else $error("ack stuck");
	ack_cause_a: assert property (wb_ack |-> $past(wb_cyc && wb_stb))
		else $error("ack unasked");
	tx_single_a: assert property ($onehot0(tx_enable))
		else $error("both buses on");
	tx_bus_a: assert property (tx_enable != 0 |-> tx_enable[reply_bus])
		else $error("wrong bus");
	reply_tx_a: assert property (reply_start |=> tx_enable[reply_bus])
		else $error("reply not sent");
	tx_limit_a: assert property (tx_run <= TX_LIMIT_CYCLES + 2)
		else $error("emission too long");
	fetch_end_a: assert property (app_req && app_ack |=> !app_req)
		else $error("fetch hangs");
endmodule
bind rt_bus_supervision_legality rt_sup_checker #(.TX_LIMIT_CYCLES(TX_LIMIT_CYCLES)) chk_i (.*);

// [test/bus_echo_model.sv]
`timescale 1ns/1ps
module bus_echo_model
	import rt_sup_pkg::*;
(
	input  wire logic  sys_clk,
	input  wire logic  bad,
	input  wire logic  tx_word_valid,
	input  wire word_t tx_word,
	output logic       echo_valid,
	output word_t      echo_word
);
	initial echo_word = 16'h0000;
	// Bus hears each word a cycle later; bad flips a bit, idle line toggles
	always @(posedge sys_clk)
	begin
		echo_valid <= tx_word_valid;
		echo_word <= tx_word_valid ? tx_word ^ {15'h0000, bad} : ~echo_word;
	end
endmodule

// [test/rt_bus_supervision_legality_tb.sv]
`timescale 1ns/1ps
module rt_bus_supervision_legality_tb
	import rt_sup_pkg::*;
;
	logic        sys_clk, nrst, wb_cyc, wb_stb, wb_we, wb_ack, timeout_select, bad, b, t;
	logic        loop_test_enable_n, rx_word_valid, rx_msg_done, tx_word_valid, echo_valid;
	logic        tx_msg_done, tx_wrap_req, rtrt_wait_start, rtrt_status_seen, app_req;
	logic        app_ack, reply_start, reply_bus, abort_pulse, data_access_enable, me;
	logic        wrap_internal_active, wrap_word_valid, noresp_timeout;
	logic [1:0]  cmd_valid, tx_enable, memory_mode;
	logic [2:0]  circular_buffer_size;
	logic [3:0]  wb_sel;
	logic [4:0]  rt_address, sa;
	logic [5:0]  expected_word_count;
	logic [7:0]  wb_adr;
	logic [31:0] wb_dat_wr, wb_dat_rd, q, cfg, seed;
	word_t       cmd_word_nom, cmd_word_red, rx_word, tx_word, echo_word, app_addr;
	word_t       app_rdata, status_word, wrap_word, cw;
	int          mismatches, checked, n, mode;

	rt_bus_supervision_legality #(.TX_LIMIT_CYCLES(200)) dut (.*);
	bus_echo_model peer (.*);

	initial
	begin
		sys_clk = 0;
		forever #4 sys_clk = ~sys_clk;
	end

	// Table answers a fetch after one cycle; idle data is garbage
	always @(posedge sys_clk)
	begin
		app_ack <= app_req & !app_ack;
		app_rdata <= app_req ? cw : ~app_rdata;
	end

	// Run should end within a few thousand cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_sim;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Receive table half from 0x0240, transmit half 0x80 above
	function automatic word_t cw_addr(logic tr, logic [4:0] s);
		return 16'h0240 + {tr, 7'h00} + s;
	endfunction

	// Buffer size, memory mode, word count (zero means 32)
	function automatic word_t fields(word_t w);
		return {w[12:10], w[7:6], (w[5:1] == 5'h00) ? 6'h20 : {1'b0, w[5:1]}};
	endfunction

	task automatic chk(word_t got, word_t exp);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wt(ref logic s, input int lim);
		for (n = 0; n < lim && s !== 1'b1; n++)
			@(posedge sys_clk);
		if (s !== 1'b1)
		begin
			mismatches++;
			$display("BAD %0t wait ran out", $time);
		end
	endtask

	// One receive word that also ends the message
	task automatic rx_one(word_t w);
		repeat (3) @(posedge sys_clk);
		{rx_word_valid, rx_msg_done, rx_word} <= {2'b11, w};
		@(posedge sys_clk);
		{rx_word_valid, rx_msg_done} <= 2'b00;
	endtask

	task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk);
		{wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_wr, wb_sel} <= {2'b11, we, a, d, 4'hf};
		@(posedge sys_clk);
		wt(wb_ack, 9);
		q = wb_dat_rd;
		{wb_cyc, wb_stb} <= 2'b00;
		@(posedge sys_clk);
	endtask

	task automatic cmd(logic [10:0] low);
		@(posedge sys_clk);
		cmd_valid <= b ? 2'b10 : 2'b01;
		cmd_word_nom <= {rt_address, low};
		cmd_word_red <= {rt_address, low};
		@(posedge sys_clk);
		cmd_valid <= 2'b00;
	endtask

	task automatic end_sim;
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial
	begin
		{nrst, wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_wr, timeout_select, bad} = '0;
		{loop_test_enable_n, cmd_valid, cmd_word_nom, cmd_word_red, rx_word_valid} = '0;
		{rx_word, rx_msg_done, tx_word_valid, tx_word, tx_msg_done, tx_wrap_req} = '0;
		{rtrt_wait_start, rtrt_status_seen, mismatches, checked, b, cw} = '0;
		seed = 32'h67b5;
		rt_address = 5'(rnd() % 31);
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		wb(1'b0, 8'h3c, 32'h0);
		chk(q[15:0], 16'h0000);
		for (int i = 0; i < 9; i++)
		begin
			mode = i % 3;
			cfg = rnd() & 32'h3;
			wb(1'b1, 8'h00, cfg);
			wb(1'b0, 8'h00, 32'h0);
			chk(q[15:0], cfg[15:0]);
			b = 1'(rnd());
			t = 1'(rnd());
			sa = 5'(rnd() % 30 + 1);
			cw = 16'(rnd()) & 16'h1cbf;
			me = cw[0] & cfg[0];
			cmd({t, sa, 5'h01});
			wt(app_req, 9);
			chk(app_addr, cw_addr(t, sa));
			if (!t)
				rx_one(16'(rnd()));
			wt(reply_start, 40);
			chk(reply_bus, b);
			chk(status_word & 16'hfc08, {rt_address, me, 10'h000});
			chk({circular_buffer_size, memory_mode, expected_word_count}, fields(cw));
			// Mode 0 ends cleanly, 1 overruns with compare off, 2 echoes wrong
			loop_test_enable_n <= (mode == 1);
			bad <= (mode != 0);
			{tx_word_valid, tx_word} <= {1'b1, 16'(rnd())};
			@(posedge sys_clk);
			tx_word_valid <= 1'b0;
			tx_msg_done <= (mode == 0);
			@(posedge sys_clk);
			tx_msg_done <= 1'b0;
			for (n = 0; n < 300 && tx_enable !== 2'b00; n++)
				@(posedge sys_clk);
			chk((mode == 1) ? (n > 190 && n < 203) : (n < 8), 1);
			wb(1'b0, 8'h0c, 32'h0);
			chk({q[13:12], q[2:0]}, {mode == 1 && b, mode == 1 && !b, mode == 2, 2'(mode == 1)});
			chk(status_word[0], mode != 0);
		end
		// No-response wait, long then short; pulse shows one edge after the count
		for (int j = 0; j < 2; j++)
		begin
			{rtrt_wait_start, timeout_select} <= {1'b1, 1'(j)};
			@(posedge sys_clk);
			rtrt_wait_start <= 1'b0;
			wt(noresp_timeout, 5000);
			chk(16'(n), 16'(j ? 14 * 125 + 1 : 31 * 125 + 1));
		end
		// Subaddress 30 word kept inside, then sent back
		{b, cw} = '0;
		cfg = rnd();
		wb(1'b1, 8'h00, 32'h2);
		cmd({1'b0, 5'h1e, 5'h01});
		wt(app_req, 9);
		rx_one(cfg[15:0]);
		chk(data_access_enable, 1);
		wt(reply_start, 40);
		cmd({1'b1, 5'h1e, 5'h01});
		wt(reply_start, 40);
		chk(wrap_internal_active, 1);
		tx_wrap_req <= 1'b1;
		@(posedge sys_clk);
		tx_wrap_req <= 1'b0;
		@(posedge sys_clk);
		chk(wrap_word_valid, 1);
		chk(wrap_word, cfg[15:0]);
		// Receive cuts the reply short; other bus during its wrap-up gets busy
		cmd({1'b0, 5'h01, 5'h01});
		@(posedge sys_clk);
		chk(abort_pulse, 1);
		rx_one(16'h0000);
		b = 1'b1;
		cmd({1'b1, 5'h01, 5'h01});
		wt(reply_start, 40);
		chk({reply_bus, status_word[3], data_access_enable}, 3'b110);
		cmd({1'b1, 5'h00, 5'h01});
		wt(app_req, 9);
		chk(app_addr, 16'h0281);
		cmd({1'b1, 5'h00, 5'h02});
		wt(reply_start, 9);
		chk(n < 3 && !app_req, 1);
		end_sim;
	end
endmodule
